/* hw/ldeu_map.vh */
// constants for the dual-word and reserved load execution unit
// assumes one 200 MHz clock and a same-clock decode stage and memory port
`ifndef LDEU_MAP_VH
`define LDEU_MAP_VH

`define LDEU_OP_W          3
`define LDEU_OP_DUAL_IMM   3'h0
`define LDEU_OP_DUAL_LIT   3'h1
`define LDEU_OP_WORD_RSV   3'h2
`define LDEU_OP_BYTE_RSV   3'h3
`define LDEU_OP_HALF_RSV   3'h4

`define LDEU_SP_IDX        4'hd
`define LDEU_SIZE_BYTE     3'h1
`define LDEU_SIZE_HALF     3'h2
`define LDEU_SIZE_WORD     3'h4
`define LDEU_WORD_STEP     32'h0000_0004
`define LDEU_IMM_SHIFT     2
`define LDEU_PC_ALIGN_MASK 2'h3

`endif

/* hw/ldeu_local_monitor.v */
// local reserved-access monitor of one processing element
// assumes set and clear come from the execution unit on the same clock
`default_nettype none
`include "ldeu_map.vh"
module ldeu_local_monitor (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire        i_set,
    input  wire [31:0] i_set_addr,
    input  wire [2:0]  i_set_size,
    input  wire        i_clear,
    output reg         o_active,
    output reg  [31:0] o_addr,
    output reg  [2:0]  o_size
);
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_active <= 1'b0;
            o_addr   <= 32'h0000_0000;
            o_size   <= 3'h0;
        end else if (i_set) begin
            // set beats a same-cycle clear so a fresh reservation is not lost
            o_active <= 1'b1;
            o_addr   <= i_set_addr;
            o_size   <= i_set_size;
        end else if (i_clear) begin
            o_active <= 1'b0;
        end
    end
endmodule // ldeu_local_monitor
`default_nettype wire

/* hw/ldeu_exec.v */
// execution of two-word loads and reserved loads with monitor arming
// assumes decode supplies register values and a same-clock memory read port
`default_nettype none
`include "ldeu_map.vh"
module ldeu_exec (
    input  wire                  i_clk_sys,
    input  wire                  i_arst_n,
    input  wire                  i_req_valid,
    input  wire [`LDEU_OP_W-1:0] i_req_op,
    input  wire                  i_cond_pass,
    input  wire                  i_bit_p,
    input  wire                  i_bit_u,
    input  wire                  i_bit_w,
    input  wire [7:0]            i_offset_field,
    input  wire [3:0]            i_base_register,
    input  wire [3:0]            i_first_destination,
    input  wire [3:0]            i_second_destination,
    input  wire [31:0]           i_base_value,
    input  wire [31:0]           i_pc_value,
    input  wire [31:0]           i_sp_limit,
    input  wire                  i_shareable,
    input  wire                  i_monitor_clear,
    input  wire                  i_mem_ack,
    input  wire [31:0]           i_mem_rdata,
    output reg                   o_busy,
    output reg                   o_done,
    output reg                   o_mem_req,
    output reg  [31:0]           o_mem_addr,
    output reg  [2:0]            o_mem_size,
    output reg                   o_rf_we,
    output reg  [3:0]            o_rf_idx,
    output reg  [31:0]           o_rf_wdata,
    output reg                   o_wb_we,
    output reg  [3:0]            o_wb_idx,
    output reg  [31:0]           o_wb_wdata,
    output reg                   o_splim_fault,
    output reg                   o_usage_fault_event,
    output reg                   o_gmon_set,
    output reg  [31:0]           o_gmon_addr,
    output reg  [2:0]            o_gmon_size,
    output wire                  o_lmon_active,
    output wire [31:0]           o_lmon_addr,
    output wire [2:0]            o_lmon_size
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RD1  = 3'b010;
    localparam [2:0] ST_RD2  = 3'b100;

    function [31:0] addsub;
        input [31:0] base;
        input [31:0] imm;
        input        add;
        begin
            addsub = add ? (base + imm) : (base - imm);
        end
    endfunction

    reg         rst_meta_ff;
    reg         rst_ff;
    reg  [2:0]  state_ff;
    reg         dual_ff;
    reg         wb_pend_ff;
    reg  [31:0] offs_addr_ff;
    reg  [3:0]  second_ff;
    reg  [3:0]  first_ff;
    reg  [1:0]  ext_ff;
    reg         lmon_set;

    // imm is offset field with two zero bits appended
    wire [31:0] imm32     = {22'h0, i_offset_field, 2'b00};
    wire [31:0] offs_addr = addsub(i_base_value, imm32, i_bit_u);
    wire [31:0] dual_addr = i_bit_p ? offs_addr : i_base_value;
    wire [31:0] lit_addr  = addsub(i_pc_value, imm32, i_bit_u);
    wire        apply_lim = (i_base_register == `LDEU_SP_IDX) && i_bit_w;
    wire        lim_bad   = apply_lim && (offs_addr < i_sp_limit);
    wire        same_dst  = (i_first_destination == i_second_destination);
    wire        wb_clash  = i_bit_w && ((i_base_register == i_first_destination) ||
                                        (i_base_register == i_second_destination));
    wire        pc_bad    = (i_pc_value[1:0] & `LDEU_PC_ALIGN_MASK) != 2'h0;
    wire        accept    = (state_ff == ST_IDLE) && i_req_valid;

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_ff      <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_ff      <= rst_meta_ff;
        end
    end

    always @* begin
        lmon_set = accept && i_cond_pass && (i_req_op == `LDEU_OP_WORD_RSV ||
                   i_req_op == `LDEU_OP_BYTE_RSV || i_req_op == `LDEU_OP_HALF_RSV);
    end

    always @(posedge i_clk_sys or negedge rst_ff) begin
        if (!rst_ff) begin
            state_ff            <= ST_IDLE;
            dual_ff             <= 1'b0;
            wb_pend_ff          <= 1'b0;
            offs_addr_ff        <= 32'h0000_0000;
            second_ff           <= 4'h0;
            first_ff            <= 4'h0;
            ext_ff              <= 2'h0;
            o_busy              <= 1'b0;
            o_done              <= 1'b0;
            o_mem_req           <= 1'b0;
            o_mem_addr          <= 32'h0000_0000;
            o_mem_size          <= 3'h0;
            o_rf_we             <= 1'b0;
            o_rf_idx            <= 4'h0;
            o_rf_wdata          <= 32'h0000_0000;
            o_wb_we             <= 1'b0;
            o_wb_idx            <= 4'h0;
            o_wb_wdata          <= 32'h0000_0000;
            o_splim_fault       <= 1'b0;
            o_usage_fault_event <= 1'b0;
            o_gmon_set          <= 1'b0;
            o_gmon_addr         <= 32'h0000_0000;
            o_gmon_size         <= 3'h0;
        end else begin
            o_done              <= 1'b0;
            o_rf_we             <= 1'b0;
            o_wb_we             <= 1'b0;
            o_splim_fault       <= 1'b0;
            o_usage_fault_event <= 1'b0;
            o_gmon_set          <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (i_req_valid) begin
                        first_ff  <= i_first_destination;
                        second_ff <= i_second_destination;
                        o_wb_idx  <= i_base_register;
                        if (!i_cond_pass) begin
                            o_done <= 1'b1;
                        end else begin
                            case (i_req_op)
                                `LDEU_OP_DUAL_IMM: begin
                                    if (same_dst || wb_clash) begin
                                        o_done <= 1'b1;
                                    end else if (lim_bad) begin
                                        // no reads; the base update itself faults
                                        o_splim_fault <= 1'b1;
                                        o_done        <= 1'b1;
                                    end else begin
                                        dual_ff      <= 1'b1;
                                        ext_ff       <= 2'h0;
                                        wb_pend_ff   <= i_bit_w;
                                        offs_addr_ff <= offs_addr;
                                        o_mem_req    <= 1'b1;
                                        o_mem_addr   <= dual_addr;
                                        o_mem_size   <= `LDEU_SIZE_WORD;
                                        o_busy       <= 1'b1;
                                        state_ff     <= ST_RD1;
                                    end
                                end
                                `LDEU_OP_DUAL_LIT: begin
                                    if (pc_bad) begin
                                        o_usage_fault_event <= 1'b1;
                                        o_done              <= 1'b1;
                                    end else if (same_dst) begin
                                        o_done <= 1'b1;
                                    end else begin
                                        dual_ff    <= 1'b1;
                                        ext_ff     <= 2'h0;
                                        wb_pend_ff <= 1'b0;
                                        o_mem_req  <= 1'b1;
                                        o_mem_addr <= lit_addr;
                                        o_mem_size <= `LDEU_SIZE_WORD;
                                        o_busy     <= 1'b1;
                                        state_ff   <= ST_RD1;
                                    end
                                end
                                `LDEU_OP_WORD_RSV, `LDEU_OP_BYTE_RSV, `LDEU_OP_HALF_RSV: begin
                                    // the local monitor, and the global one when shareable, are armed on the same edge that issues the read
                                    dual_ff     <= 1'b0;
                                    wb_pend_ff  <= 1'b0;
                                    o_mem_req   <= 1'b1;
                                    o_busy      <= 1'b1;
                                    o_gmon_set  <= i_shareable;
                                    state_ff    <= ST_RD1;
                                    if (i_req_op == `LDEU_OP_WORD_RSV) begin
                                        ext_ff      <= 2'h0;
                                        o_mem_addr  <= i_base_value + imm32;
                                        o_gmon_addr <= i_base_value + imm32;
                                        o_mem_size  <= `LDEU_SIZE_WORD;
                                        o_gmon_size <= `LDEU_SIZE_WORD;
                                    end else if (i_req_op == `LDEU_OP_BYTE_RSV) begin
                                        ext_ff      <= 2'h1;
                                        o_mem_addr  <= i_base_value;
                                        o_gmon_addr <= i_base_value;
                                        o_mem_size  <= `LDEU_SIZE_BYTE;
                                        o_gmon_size <= `LDEU_SIZE_BYTE;
                                    end else begin
                                        ext_ff      <= 2'h2;
                                        o_mem_addr  <= i_base_value;
                                        o_gmon_addr <= i_base_value;
                                        o_mem_size  <= `LDEU_SIZE_HALF;
                                        o_gmon_size <= `LDEU_SIZE_HALF;
                                    end
                                end
                                default: begin
                                    o_done <= 1'b1;
                                end
                            endcase
                        end
                    end
                end
                ST_RD1: begin
                    if (i_mem_ack) begin
                        o_rf_we  <= 1'b1;
                        o_rf_idx <= first_ff;
                        case (ext_ff)
                            2'h1:    o_rf_wdata <= {24'h0, i_mem_rdata[7:0]};
                            2'h2:    o_rf_wdata <= {16'h0, i_mem_rdata[15:0]};
                            default: o_rf_wdata <= i_mem_rdata;
                        endcase
                        if (dual_ff) begin
                            o_mem_addr <= o_mem_addr + `LDEU_WORD_STEP;
                            state_ff   <= ST_RD2;
                        end else begin
                            o_mem_req <= 1'b0;
                            o_busy    <= 1'b0;
                            o_done    <= 1'b1;
                            state_ff  <= ST_IDLE;
                        end
                    end
                end
                ST_RD2: begin
                    if (i_mem_ack) begin
                        o_rf_we    <= 1'b1;
                        o_rf_idx   <= second_ff;
                        o_rf_wdata <= i_mem_rdata;
                        o_wb_we    <= wb_pend_ff;
                        o_wb_wdata <= offs_addr_ff;
                        o_mem_req  <= 1'b0;
                        o_busy     <= 1'b0;
                        o_done     <= 1'b1;
                        state_ff   <= ST_IDLE;
                    end
                end
                default: begin
                    o_mem_req <= 1'b0;
                    o_busy    <= 1'b0;
                    state_ff  <= ST_IDLE;
                end
            endcase
        end
    end

    // monitor state flops are the outputs themselves
    ldeu_local_monitor u_lmon (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (rst_ff),
        .i_set      (lmon_set),
        .i_set_addr ((i_req_op == `LDEU_OP_WORD_RSV) ? (i_base_value + imm32) : i_base_value),
        .i_set_size ((i_req_op == `LDEU_OP_WORD_RSV) ? `LDEU_SIZE_WORD :
                     (i_req_op == `LDEU_OP_BYTE_RSV) ? `LDEU_SIZE_BYTE : `LDEU_SIZE_HALF),
        .i_clear    (i_monitor_clear),
        .o_active   (o_lmon_active),
        .o_addr     (o_lmon_addr),
        .o_size     (o_lmon_size)
    );
endmodule // ldeu_exec
`default_nettype wire

/* testbench/ldeu_mem_model.sv */
// memory port model for the load unit: answers each read after a set wait
// assumes a held request level and one clock shared with the unit
`default_nettype none
module ldeu_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [3:0]  i_lat,
    output var  logic        o_ack,
    output var  logic [31:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt = 0;
    initial o_ack = 1'b0;
    initial o_rdata = 32'h0;
    always @(posedge i_clk_sys) begin
        #1;
        if (i_req === 1'b1 && o_ack !== 1'b1 && wait_cnt >= i_lat) begin
            o_ack = 1'b1;
            o_rdata = {i_addr[15:0], ~i_addr[15:0]};
            wait_cnt = 0;
        end else begin
            o_ack = 1'b0;
            // data flips when not acked, so a word one cycle stale never matches
            o_rdata = ~o_rdata;
            wait_cnt = (i_req === 1'b1) ? wait_cnt + 1 : 0;
        end
    end
endmodule // ldeu_mem_model
`default_nettype wire

/* testbench/ldeu_exec_sva.sv */
// port checker for the two-word and reserved load unit
// assumes one clock; bound to the unit's top module at the foot of the file
`default_nettype none
`include "ldeu_map.vh"
module ldeu_exec_sva (
    input wire logic                  i_clk_sys, i_arst_n, i_req_valid, i_cond_pass, i_mem_ack,
    input wire logic                  i_bit_p, i_bit_u, i_bit_w, i_shareable, i_monitor_clear,
    input wire logic [`LDEU_OP_W-1:0] i_req_op,
    input wire logic [7:0]            i_offset_field,
    input wire logic [3:0]            i_base_register, i_first_destination, i_second_destination,
    input wire logic [31:0]           i_base_value, i_pc_value, i_sp_limit,
    input wire logic                  o_busy, o_done, o_mem_req, o_rf_we, o_wb_we, o_splim_fault,
    input wire logic                  o_usage_fault_event, o_gmon_set, o_lmon_active,
    input wire logic [31:0]           o_mem_addr, o_gmon_addr, o_lmon_addr,
    input wire logic [2:0]            o_mem_size, o_gmon_size, o_lmon_size
);
    timeunit 1ns;
    timeprecision 1ps;
    wire        take = i_req_valid && !o_busy;
    wire        go   = take && i_cond_pass;
    wire [31:0] imm  = {22'h0, i_offset_field, 2'b00};
    wire [31:0] offa = i_bit_u ? i_base_value + imm : i_base_value - imm;
    wire [31:0] lita = i_bit_u ? i_pc_value + imm : i_pc_value - imm;
    wire [31:0] dua  = i_bit_p ? offa : i_base_value;
    wire        difd = i_first_destination != i_second_destination;
    wire        sane = difd && !(i_bit_w && (i_base_register == i_first_destination ||
                                             i_base_register == i_second_destination));
    wire        dual = go && sane && i_req_op == `LDEU_OP_DUAL_IMM;
    wire        lim  = i_bit_w && i_base_register == `LDEU_SP_IDX;
    wire        lit  = go && difd && i_req_op == `LDEU_OP_DUAL_LIT;
    wire        wrsv = i_req_op == `LDEU_OP_WORD_RSV;
    wire        rsv  = go && (wrsv || i_req_op == `LDEU_OP_BYTE_RSV ||
                              i_req_op == `LDEU_OP_HALF_RSV);
    wire [31:0] rsa  = wrsv ? i_base_value + imm : i_base_value;
    wire [2:0]  rsz  = wrsv ? 3'h4 : (i_req_op == `LDEU_OP_BYTE_RSV) ? 3'h1 : 3'h2;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    a_req_holds_addr: assert property (o_mem_req && !i_mem_ack |=> o_mem_req &&
        $stable(o_mem_addr) && $stable(o_mem_size)) else $error("read request dropped early");
    a_req_in_busy: assert property (o_mem_req |-> o_busy) else $error("read while idle");
    a_second_word: assert property (o_mem_req && i_mem_ack |=> !o_mem_req ||
        o_mem_addr == $past(o_mem_addr) + 32'h4) else $error("second word address wrong");
    a_dual_addr: assert property (dual &&
        (!lim || offa >= i_sp_limit) |=>
        o_mem_req && !o_splim_fault && o_mem_addr == $past(dua) && o_mem_size == 3'h4)
        else $error("two-word load address wrong");
    a_limit_fault: assert property (dual && lim && offa < i_sp_limit |=>
        o_splim_fault && o_done && !o_mem_req) else $error("stack limit not enforced");
    a_lit_addr: assert property (lit && i_pc_value[1:0] == 2'h0 |=>
        o_mem_req && o_mem_addr == $past(lita)) else $error("pc-relative address wrong");
    a_pc_misalign: assert property (lit && i_pc_value[1:0] != 2'h0 |=>
        o_usage_fault_event && o_done && !o_mem_req) else $error("misaligned pc not faulted");
    a_rsv_arm: assert property (rsv |=> o_mem_req &&
        o_mem_addr == $past(rsa) && o_mem_size == $past(rsz) &&
        o_gmon_set == $past(i_shareable) && o_lmon_active)
        else $error("reserved load arming wrong");
    a_monitors_agree: assert property (o_gmon_set |-> o_gmon_addr == o_lmon_addr &&
        o_gmon_size == o_lmon_size) else $error("monitors disagree");
    a_same_dest_nop: assert property (go && i_req_op <= 3'h1 && !difd |=>
        o_done && !o_mem_req ##1 !o_rf_we) else $error("equal destinations not a nop");
    a_cond_fail_quiet: assert property (take && !i_cond_pass && !i_monitor_clear |=>
        o_done && !o_mem_req && !o_gmon_set && $stable(o_lmon_active) ##1 !o_rf_we && !o_wb_we)
        else $error("failed condition had effects");
    a_wb_at_end: assert property (o_wb_we |-> o_done && !o_splim_fault)
        else $error("writeback out of place");
    c_dual_wb: cover property (dual && i_bit_w);
    c_limit: cover property (o_splim_fault);
    c_shared: cover property (o_gmon_set);
endmodule // ldeu_exec_sva
bind ldeu_exec ldeu_exec_sva u_sva (.*);
`default_nettype wire

/* testbench/load_dual_exclusive_unit_test.sv */
// self-checking bench for the two-word and reserved load unit
// assumes the unit's header on the include path and the memory model beside it
`default_nettype none
`include "ldeu_map.vh"
module load_dual_exclusive_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 1'b0, i_arst_n = 1'b0, i_req_valid = 1'b0, i_cond_pass = 1'b0;
    logic        i_bit_p = 1'b0, i_bit_u = 1'b0, i_bit_w = 1'b0, i_shareable = 1'b0;
    logic        i_monitor_clear = 1'b0;
    logic [`LDEU_OP_W-1:0] i_req_op = 3'h0;
    logic [7:0]  i_offset_field = 8'h00;
    logic [3:0]  i_base_register = 4'h0, i_first_destination = 4'h0, i_second_destination = 4'h0;
    logic [31:0] i_base_value = 32'h0, i_pc_value = 32'h0, i_sp_limit = 32'h0;
    logic [3:0]  mem_lat = 4'h0;
    wire         i_mem_ack, o_busy, o_done, o_mem_req, o_rf_we, o_wb_we, o_splim_fault;
    wire         o_usage_fault_event, o_gmon_set, o_lmon_active;
    wire [31:0]  i_mem_rdata, o_mem_addr, o_rf_wdata, o_wb_wdata, o_gmon_addr, o_lmon_addr;
    wire [3:0]   o_rf_idx, o_wb_idx;
    wire [2:0]   o_mem_size, o_gmon_size, o_lmon_size;
    int          errors = 0, samples_checked = 0, n_rf, n_rd;
    logic [31:0] rf_dat [2], rd_addr [2], wb_dat;
    logic [3:0]  rf_idx [2], wb_idx;
    logic [2:0]  rd_size;
    logic        wb_seen, sp_f, us_f, gm_f;

    ldeu_exec DUT (.*);
    ldeu_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_req(o_mem_req), .i_addr(o_mem_addr),
                          .i_lat(mem_lat), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

    function automatic logic [31:0] mdat(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // flags are packed as condition, index, add, writeback
    task automatic issue(input logic [2:0] op, input logic [3:0] cpuw, input logic [7:0] off,
                         input logic [3:0] rn, rt, rt2, input logic [31:0] base, pcv, lim,
                         input logic shr);
        int k;
        @(posedge i_clk_sys);
        #1;
        {i_cond_pass, i_bit_p, i_bit_u, i_bit_w} = cpuw;
        {i_req_op, i_offset_field, i_base_register, i_first_destination} = {op, off, rn, rt};
        {i_second_destination, i_base_value, i_pc_value, i_sp_limit} = {rt2, base, pcv, lim};
        {i_shareable, i_req_valid} = {shr, 1'b1};
        do @(negedge i_clk_sys); while (o_busy === 1'b1);
        @(posedge i_clk_sys);
        #1;
        i_req_valid = 1'b0;
        n_rf = 0;
        n_rd = 0;
        // fault and nop pulses come with done at the accept edge, before the loop samples
        {wb_seen, sp_f, us_f, gm_f} = {1'b0, o_splim_fault === 1'b1,
                                       o_usage_fault_event === 1'b1, o_gmon_set === 1'b1};
        for (k = 0; k < 60 && o_done !== 1'b1; k++) begin
            @(negedge i_clk_sys);
            if (o_rf_we === 1'b1 && n_rf < 2) begin
                {rf_idx[n_rf], rf_dat[n_rf]} = {o_rf_idx, o_rf_wdata};
                n_rf++;
            end
            if (o_mem_req === 1'b1 && i_mem_ack === 1'b1 && n_rd < 2) begin
                {rd_addr[n_rd], rd_size} = {o_mem_addr, o_mem_size};
                n_rd++;
            end
            if (o_wb_we === 1'b1) {wb_seen, wb_idx, wb_dat} = {1'b1, o_wb_idx, o_wb_wdata};
            sp_f |= (o_splim_fault === 1'b1);
            us_f |= (o_usage_fault_event === 1'b1);
            gm_f |= (o_gmon_set === 1'b1);
        end
        chk(o_done, 1'b1);
    endtask

    task automatic t_dual();
        mem_lat = 4'h2;
        issue(`LDEU_OP_DUAL_IMM, 4'b1111, 8'hff, 4'h2, 4'h4, 4'h5, 32'h1000, 32'h0, 32'h0, 1'b0);
        chk(n_rd, 2);
        chk(rd_addr[0], 32'h13fc);
        chk({rd_addr[1], rd_size}, {32'h1400, 3'h4});
        chk({rf_idx[0], rf_idx[1]}, 8'h45);
        chk(rf_dat[0], mdat(32'h13fc));
        chk(rf_dat[1], mdat(32'h1400));
        chk({wb_seen, wb_idx, wb_dat}, {1'b1, 4'h2, 32'h13fc});
        mem_lat = 4'h0;
        issue(`LDEU_OP_DUAL_IMM, 4'b1001, 8'h01, 4'h3, 4'h0, 4'h1, 32'h2000, 32'h0, 32'h0, 1'b0);
        chk(rd_addr[0], 32'h2000);
        chk(rd_addr[1], 32'h2004);
        chk(wb_dat, 32'h1ffc);
    endtask
    task automatic t_limit();
        // limit sits one word above, exactly at, and above with a plain base
        for (int j = 0; j < 3; j++) begin
            issue(`LDEU_OP_DUAL_IMM, 4'b1101, 8'h04, (j == 2) ? 4'hc : 4'hd, 4'h0, 4'h1,
                  32'h3000, 32'h0, (j == 1) ? 32'h2ff0 : 32'h2ff4, 1'b0);
            chk(n_rd, (j == 0) ? 0 : 2);
            chk(sp_f, j == 0);
            chk(wb_seen, j != 0);
        end
    endtask
    task automatic t_lit();
        issue(`LDEU_OP_DUAL_LIT, 4'b1001, 8'h02, 4'hf, 4'h0, 4'h1, 32'h0, 32'h4000, 32'h0, 1'b0);
        chk(rd_addr[0], 32'h3ff8);
        chk(rd_addr[1], 32'h3ffc);
        chk(wb_seen, 1'b0);
        issue(`LDEU_OP_DUAL_LIT, 4'b1110, 8'hff, 4'hf, 4'h0, 4'h1, 32'h0, 32'h4000, 32'h0, 1'b0);
        chk(rd_addr[0], 32'h43fc);
        issue(`LDEU_OP_DUAL_LIT, 4'b1110, 8'h01, 4'hf, 4'h0, 4'h1, 32'h0, 32'h4002, 32'h0, 1'b0);
        chk({us_f, n_rd[1:0]}, 3'h4);
    endtask
    task automatic t_nop();
        issue(`LDEU_OP_DUAL_IMM, 4'b1100, 8'h01, 4'h2, 4'h6, 4'h6, 32'h1000, 32'h0, 32'h0, 1'b0);
        chk(n_rd + n_rf, 0);
        issue(`LDEU_OP_DUAL_IMM, 4'b1101, 8'h01, 4'h6, 4'h6, 4'h7, 32'h1000, 32'h0, 32'h0, 1'b0);
        chk(n_rd + n_rf + wb_seen, 0);
    endtask
    task automatic t_rsv();
        logic [31:0] b, a, m;
        logic [2:0]  sz;
        mem_lat = 4'h3;
        for (int j = 0; j < 3; j++) begin
            b = 32'h5000 + 32'h100 * j;
            a = b + ((j == 0) ? 32'h40 : 32'h0);
            m = (j == 0) ? 32'hffff_ffff : (j == 1) ? 32'h0000_00ff : 32'h0000_ffff;
            sz = (j == 0) ? 3'h4 : (j == 1) ? 3'h1 : 3'h2;
            issue(`LDEU_OP_WORD_RSV + 3'(j), 4'b1000, 8'h10, 4'h1, 4'h8, 4'h9, b, 32'h0, 32'h0,
                  j == 1);
            chk(rd_addr[0], a);
            chk(rd_size, sz);
            chk({rf_idx[0], rf_dat[0]}, {4'h8, mdat(a) & m});
            chk(gm_f, j == 1);
            chk({o_lmon_active, o_lmon_size, o_lmon_addr}, {1'b1, sz, a});
        end
        mem_lat = 4'h0;
    endtask
    task automatic t_cond();
        @(posedge i_clk_sys);
        #1;
        i_monitor_clear = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_monitor_clear = 1'b0;
        @(negedge i_clk_sys);
        chk(o_lmon_active, 1'b0);
        issue(`LDEU_OP_WORD_RSV, 4'b0000, 8'h00, 4'h1, 4'h8, 4'h9, 32'h6000, 32'h0, 32'h0, 1'b1);
        chk(n_rd + n_rf + gm_f + o_lmon_active, 0);
        issue(`LDEU_OP_DUAL_IMM, 4'b0111, 8'h01, 4'h2, 4'h4, 4'h5, 32'h1000, 32'h0, 32'h0, 1'b0);
        chk(n_rd + n_rf + wb_seen, 0);
    endtask
    task automatic end_of_test();
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial forever #2.5 i_clk_sys = ~i_clk_sys;
    // whole run is a few hundred cycles; this bound of 20000 cycles only catches a hang
    initial begin
        #100000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge i_clk_sys);
        #1;
        i_arst_n = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk({o_busy, o_lmon_active}, 2'h0);
        t_dual();
        t_limit();
        t_lit();
        t_nop();
        t_rsv();
        t_cond();
        end_of_test();
    end
endmodule // load_dual_exclusive_unit_test
`default_nettype wire
